// File: rtl/fifo_pkg.sv
package fifo_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int           ADDR_W        = 8;
	localparam int           DATA_W        = 18;
	localparam int           COUNT_W       = 9;
	localparam logic [8:0]   DEPTH_WORDS   = 9'h0100;
	localparam logic [8:0]   COUNT_EMPTY   = 9'h0000;
	localparam logic [7:0]   LAST_LOCATION = 8'h00ff;
	localparam logic [7:0]   PTR_RESET     = 8'h0000;
	localparam logic [17:0]  DOUT_RESET    = 18'h0_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS            = 10;
	localparam int RETRANSMIT_RECOVERY_TIME = 12;
	// Least time, rounded up to whole cycles
	localparam int RTR_CYCLES =
		(RETRANSMIT_RECOVERY_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] RTR_LOAD  = 2'(RTR_CYCLES);
	localparam logic [1:0] RTR_IDLE  = 2'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic full_flag_n;
		logic empty_flag_n;
		logic almost_empty_flag_n;
		logic almost_full_flag_n;
	} flags_t;

	typedef struct packed {
		logic [7:0]  wr_ptr;
		logic [7:0]  rd_ptr;
		logic [8:0]  count;
		logic [17:0] dout;
		logic        ae_sync_n;
		logic        af_sync_n;
		logic        wco;
		logic        rco;
		logic [1:0]  rtr_cnt;
	} state_t;

	localparam state_t STATE_RESET = '{
		wr_ptr:    PTR_RESET,
		rd_ptr:    PTR_RESET,
		count:     COUNT_EMPTY,
		dout:      DOUT_RESET,
		ae_sync_n: 1'b0,
		af_sync_n: 1'b1,
		wco:       1'b0,
		rco:       1'b0,
		rtr_cnt:   RTR_IDLE
	};

endpackage

// File: rtl/fifo_store.sv
`timescale 1ns/1ps
`default_nettype none

// Word store: written on the clock, read through without a register
module fifo_store
	import fifo_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              wr_strobe,
	input  wire logic [7:0]        wr_addr,
	input  wire logic [17:0]       wr_word,
	input  wire logic [7:0]        rd_addr,
	output logic      [17:0]       rd_word
);

	logic [17:0] mem [0:255];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// No reset on the array; contents are don't-care until written
	always_ff @(posedge ref_clk)
	begin
		if (wr_strobe)
		begin
			mem[wr_addr] <= wr_word;
		end
	end

	assign rd_word = mem[rd_addr];

endmodule

`default_nettype wire

// File: rtl/sync_fifo_flag_timing.sv
`timescale 1ns/1ps
`default_nettype none

module sync_fifo_flag_timing
	import fifo_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        wr_en,
	input  wire logic [17:0] wr_data,
	input  wire logic        rd_en,
	input  wire logic        out_enable_n,
	input  wire logic        sync_flag_select,
	input  wire logic        retransmit,
	input  wire logic [8:0]  ae_offset,
	input  wire logic [8:0]  af_offset,
	output logic      [17:0] rd_data,
	output logic             rd_data_oe,
	output flags_t           flags,
	output logic             write_cascade_out,
	output logic             read_cascade_out
);

	state_t      s;
	state_t      next_s;
	logic        do_wr;
	logic        do_rd;
	logic [17:0] store_word;
	logic        ae_now_n;
	logic        af_now_n;

	// ------------------------------------------------------------
	// Access qualification
	// ------------------------------------------------------------
	// Reads are held off while retransmit recovers so flags settle
	assign do_wr = wr_en && (s.count != DEPTH_WORDS);
	assign do_rd = rd_en && (s.count != COUNT_EMPTY)
		&& (s.rtr_cnt == RTR_IDLE) && !retransmit;

	fifo_store u_store (
		.ref_clk   (ref_clk),
		.wr_strobe (do_wr),
		.wr_addr   (s.wr_ptr),
		.wr_word   (wr_data),
		.rd_addr   (s.rd_ptr),
		.rd_word   (store_word)
	);

	// ------------------------------------------------------------
	// Almost thresholds
	// ------------------------------------------------------------
	// Low while fewer than n words remain
	assign ae_now_n = (s.count >= ae_offset);
	// Low once count reaches depth - m + 1
	assign af_now_n = (s.count <= 9'(DEPTH_WORDS - af_offset));

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_s     = s;
		next_s.wco = 1'b0;
		next_s.rco = 1'b0;
		if (do_wr)
		begin
			next_s.wr_ptr = s.wr_ptr + 8'h0001;
			next_s.wco    = (s.wr_ptr == LAST_LOCATION);
		end
		if (do_rd)
		begin
			next_s.rd_ptr = s.rd_ptr + 8'h0001;
			next_s.dout   = store_word;
			next_s.rco    = (s.rd_ptr == LAST_LOCATION);
		end
		// One clock serves both ports, so the skew is always met
		case ({do_wr, do_rd})
			2'b10:   next_s.count = s.count + 9'h0001;
			2'b01:   next_s.count = s.count - 9'h0001;
			default: next_s.count = s.count;
		endcase
		// Registered flags lag the count by one edge
		next_s.ae_sync_n = ae_now_n;
		next_s.af_sync_n = af_now_n;
		if (s.rtr_cnt != RTR_IDLE)
		begin
			next_s.rtr_cnt = s.rtr_cnt - 2'h1;
		end
		// Rewind reads to the start; pointer offset sets the count
		if (retransmit)
		begin
			next_s.rd_ptr  = PTR_RESET;
			next_s.count   = {1'b0, next_s.wr_ptr};
			next_s.rtr_cnt = RTR_LOAD;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Synchronous reset, so a running clock through reset is fine
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s <= STATE_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rd_data    = s.dout;
	assign rd_data_oe = !out_enable_n;
	assign flags.full_flag_n  = (s.count != DEPTH_WORDS);
	assign flags.empty_flag_n = (s.count != COUNT_EMPTY);
	// Select low picks the registered timing
	assign flags.almost_empty_flag_n =
		sync_flag_select ? ae_now_n : s.ae_sync_n;
	assign flags.almost_full_flag_n =
		sync_flag_select ? af_now_n : s.af_sync_n;
	assign write_cascade_out = s.wco;
	assign read_cascade_out  = s.rco;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence full_read_s;
		!flags.full_flag_n && rd_en && !wr_en && !retransmit
			&& (s.rtr_cnt == RTR_IDLE);
	endsequence

	// Sampled reset: a write on the last reset edge is dropped
	sequence empty_write_s;
		!flags.empty_flag_n && wr_en && !retransmit && !sys_rst;
	endsequence

	sequence first_read_s;
		flags.empty_flag_n && rd_en && !retransmit
			&& (s.rtr_cnt == RTR_IDLE);
	endsequence

	full_release_a: assert property (full_read_s |=> flags.full_flag_n)
		else $error("full flag not released after read");

	empty_release_a: assert property (empty_write_s |=> flags.empty_flag_n)
		else $error("empty flag not released after write");

	// Own disable: the default one would make this vacuous
	reset_flags_a: assert property (@(posedge ref_clk)
		disable iff (1'b0)
		sys_rst |=> !flags.empty_flag_n && flags.full_flag_n
			&& (rd_data == DOUT_RESET))
		else $error("flags or data wrong after reset");

	first_word_a: assert property (empty_write_s ##1 first_read_s
		|=> rd_data == $past(wr_data, 2))
		else $error("first word not delivered after empty");

	// Count moves by at most one per edge outside retransmit, so a fall
	// of the direct flag pins the fill level exactly
	async_almost_empty_a: assert property (sync_flag_select
		&& $stable(sync_flag_select) && $stable(ae_offset)
		&& !$past(retransmit) && $fell(flags.almost_empty_flag_n)
		|-> s.count == ae_offset - 9'h001)
		else $error("almost-empty threshold wrong");

	async_almost_full_a: assert property (sync_flag_select
		&& $stable(sync_flag_select) && $stable(af_offset)
		&& !$past(retransmit) && $fell(flags.almost_full_flag_n)
		|-> s.count == 9'(DEPTH_WORDS - af_offset + 9'h001))
		else $error("almost-full threshold wrong");

	sync_almost_lag_a: assert property (!sync_flag_select ##1
		!sync_flag_select |-> flags.almost_empty_flag_n
			== ($past(s.count) >= $past(ae_offset)))
		else $error("registered almost-empty timing wrong");

	sync_full_lag_a: assert property (!sync_flag_select ##1
		!sync_flag_select |-> flags.almost_full_flag_n
			== ($past(s.count) <= 9'(DEPTH_WORDS - $past(af_offset))))
		else $error("registered almost-full timing wrong");

	retransmit_recover_a: assert property (retransmit && !$past(retransmit)
		|-> ##[1:3] (s.rtr_cnt == RTR_IDLE))
		else $error("retransmit recovery too long");

	write_cascade_a: assert property (do_wr && (s.wr_ptr == LAST_LOCATION)
		|=> write_cascade_out ##1 !write_cascade_out)
		else $error("write cascade pulse missing");

	read_cascade_a: assert property (do_rd && (s.rd_ptr == LAST_LOCATION)
		|=> read_cascade_out)
		else $error("read cascade pulse missing");

	// Reads stay refused until recovery ends, so data must hold
	recovery_hold_a: assert property ((retransmit
		|| (s.rtr_cnt != RTR_IDLE)) |=> $stable(rd_data))
		else $error("read taken during retransmit recovery");

	write_cascade_only_a: assert property (write_cascade_out
		|-> $past(do_wr) && ($past(s.wr_ptr) == LAST_LOCATION))
		else $error("write cascade pulse without last-slot write");

	read_cascade_only_a: assert property (read_cascade_out
		|-> $past(do_rd) && ($past(s.rd_ptr) == LAST_LOCATION))
		else $error("read cascade pulse without last-slot read");

endmodule

`default_nettype wire

// File: testbench/stream_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side writer and reader, changing pins just after each edge
module stream_peer
(
	input  wire logic        ref_clk,
	input  wire logic        want_wr,
	input  wire logic        want_rd,
	input  wire logic [17:0] word,
	output logic             wr_en,
	output logic      [17:0] wr_data,
	output logic             rd_en
);
	// Quiet pins at time zero
	initial
	begin
		wr_en = 1'b0;
		wr_data = 18'h0_0000;
		rd_en = 1'b0;
	end
	// Idle data toggles so no stale word can pass for a real one
	always @(posedge ref_clk)
	begin
		wr_en <= want_wr;
		rd_en <= want_rd;
		wr_data <= want_wr ? word : ~wr_data;
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import fifo_pkg::*;
	logic        ref_clk, sys_rst, want_wr, want_rd, retransmit;
	logic        rd_ok, wr_ok;
	logic        wr_en, rd_en, out_enable_n, sync_flag_select;
	logic        rd_data_oe, write_cascade_out, read_cascade_out;
	logic [17:0] word, wr_data, rd_data, e_dout;
	logic [8:0]  ae_offset, af_offset;
	logic [7:0]  wa, ra;
	logic [31:0] seed;
	logic        e_wco, e_rco, ae_s, af_s;
	flags_t      flags, ef;
	logic [17:0] mm [0:255];
	int          num_errors, compares, cnt, rtr;

	stream_peer stream_peer_i (.ref_clk, .want_wr, .want_rd, .word,
		.wr_en, .wr_data, .rd_en);
	sync_fifo_flag_timing sync_fifo_flag_timing_i (.ref_clk, .sys_rst,
		.wr_en, .wr_data, .rd_en, .out_enable_n, .sync_flag_select,
		.retransmit, .ae_offset, .af_offset, .rd_data, .rd_data_oe,
		.flags, .write_cascade_out, .read_cascade_out);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// Registered almost flags lag the count decode by one edge
	function automatic flags_t exp_flags(input int c);
		flags_t f;
		f.full_flag_n = (c != 256);
		f.empty_flag_n = (c != 0);
		f.almost_empty_flag_n = sync_flag_select ? (c >= ae_offset) : ae_s;
		f.almost_full_flag_n = sync_flag_select ? (c < 257 - af_offset) : af_s;
		return f;
	endfunction

	task automatic chk(input string nm, input logic [17:0] e, s);
		compares++;
		if (e !== s)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Reference model; refused accesses leave it untouched
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wa = 8'h00;
			ra = 8'h00;
			cnt = 0;
			rtr = 0;
			e_dout = 18'h0_0000;
			e_wco = 1'b0;
			e_rco = 1'b0;
			ae_s = 1'b0;
			af_s = 1'b1;
		end
		else
		begin
			ae_s = cnt >= ae_offset;
			af_s = cnt < 257 - af_offset;
			e_wco = 1'b0;
			e_rco = 1'b0;
			// Reads wait out the whole retransmit recovery
			rd_ok = rd_en && cnt != 0 && rtr == 0 && !retransmit;
			wr_ok = wr_en && cnt != 256;
			if (rtr != 0)
				rtr--;
			if (rd_ok)
			begin
				e_dout = mm[ra];
				e_rco = (ra == 8'hff);
				ra++;
				cnt--;
			end
			if (wr_ok)
			begin
				mm[wa] = wr_data;
				e_wco = (wa == 8'hff);
				wa++;
				cnt++;
			end
			// Rewind: reads restart at slot 0, count follows writes
			if (retransmit)
			begin
				ra = 8'h00;
				cnt = wa;
				rtr = RTR_CYCLES;
			end
		end
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Main sequence: fill to refusal, drain to empty, reset mid-run
	// ----------------------------------------
	initial
	begin
		seed = 32'h0000_94ab;
		sys_rst = 1'b1;
		{want_wr, want_rd, out_enable_n, sync_flag_select} = 4'h0;
		retransmit = 1'b0;
		word = 18'h0_0000;
		ae_offset = 9'h001;
		af_offset = 9'h001;
		repeat (16) @(posedge ref_clk);
		for (int ph = 0; ph < 4; ph++)
		begin
			sync_flag_select <= ph[0];
			ae_offset <= 9'(seed[6:0]) + 9'h001;
			af_offset <= 9'(seed[14:8]) + 9'h001;
			for (int i = 0; i < 1200; i++)
			begin
				seed = xs(seed);
				// Clock keeps running through the second reset
				sys_rst <= (i < 3) && (ph != 1);
				want_wr <= seed[3:0] < (i < 600 ? 13 : 3);
				want_rd <= seed[7:4] < (i < 600 ? 3 : 13);
				word <= seed[31:14];
				out_enable_n <= seed[9];
				// Spaced pulses leave the extra cycle sync flags need
				retransmit <= (ph > 1) && (i % 97 == 50);
				@(negedge ref_clk);
				ef = exp_flags(cnt);
				chk("full_empty", 18'(ef[3:2]), 18'(flags[3:2]));
				chk("almost", 18'(ef[1:0]), 18'(flags[1:0]));
				chk("rd_data", e_dout, rd_data);
				chk("oe", 18'(!out_enable_n), 18'(rd_data_oe));
				chk("wr_casc", 18'(e_wco), 18'(write_cascade_out));
				chk("rd_casc", 18'(e_rco), 18'(read_cascade_out));
				@(posedge ref_clk);
			end
			$display("Test phase %0d ended", ph);
		end
		complete_run();
	end
endmodule
`default_nettype wire
